// >>> core/can_timing_pkg.sv
// constants and types shared by the can bit timing and fault state block
package can_timing_pkg;
  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_TIMING = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_ERRCNT = 8'h0C;
  localparam logic [7:0] OFS_BITDIV = 8'h10;
  // ==========================================================
  // control field positions
  localparam int CTRL_ACTIVE = 0;
  localparam int CTRL_LISTEN = 1;
  localparam int CTRL_RESET = 2;
  // ==========================================================
  // timing field positions (each field holds its value minus one)
  localparam int TIM_PRESC_LSB = 0;
  localparam int TIM_PROP_LSB = 8;
  localparam int TIM_PH1_LSB = 12;
  localparam int TIM_PH2_LSB = 16;
  localparam int TIM_SJW_LSB = 20;
  // ==========================================================
  // status field positions
  localparam int ST_ACTIVE = 0;
  localparam int ST_LISTEN = 1;
  localparam int ST_FAULT_LSB = 2;
  localparam int ST_LIGHT = 4;
  localparam int ST_HEAVY = 5;
  localparam int ST_BUS_OFF = 6;
  localparam int ST_CFG_ERR = 7;
  // ==========================================================
  // reset values: prescaler 10, prop 3, phase1 4, phase2 4, jump 1
  localparam logic [31:0] TIMING_RESET = 32'h0003_3209;
  localparam logic CTRL_ACTIVE_RESET = 1'b0;
  localparam logic CTRL_LISTEN_RESET = 1'b0;
  // ==========================================================
  // bit timing limits in time quanta
  localparam logic [4:0] SYNC_LEN = 5'h01;
  localparam logic [4:0] TSEG1_MIN = 5'h04;
  localparam logic [2:0] PH2_M1_MIN = 3'h1;
  // ==========================================================
  // error count thresholds
  localparam logic [8:0] PASSIVE_ABOVE = 9'h07F;
  localparam int CNT_W = 9;
  // ==========================================================
  // states
  typedef enum logic [1:0] {
    SEG_SYNC = 2'b00,
    SEG_ONE = 2'b01,
    SEG_TWO = 2'b11
  } seg_e;
  typedef enum logic [1:0] {
    F_CLEAN = 2'b00,
    F_ERR_ACTIVE = 2'b01,
    F_ERR_PASSIVE = 2'b11,
    F_BUS_OFF = 2'b10
  } fault_e;
endpackage

// >>> core/tq_link_if.sv
// link between the bit timing core and its time quantum generator
`timescale 1ns/100ps
`default_nettype none
interface tq_link_if;
  logic [7:0] div_m1;
  logic restart;
  logic tick;
  modport ctrl (output div_m1, output restart, input tick);
  modport gen (input div_m1, input restart, output tick);
endinterface
`default_nettype wire

// >>> core/tq_prescaler.sv
// time quantum generator: divides the core clock by the prescaler
`timescale 1ns/100ps
`default_nettype none
module tq_prescaler
  import can_timing_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  tq_link_if.gen link
);
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic tick_q;
  logic tick_d;

  // ==========================================================
  // divider: one tick every div_m1 + 1 clocks, restart realigns it
  always_comb begin
    tick_d = 1'b0;
    cnt_d = cnt_q + 8'h01;
    if (link.restart) begin
      cnt_d = 8'h00;
    end else if (cnt_q >= link.div_m1) begin
      cnt_d = 8'h00;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_q <= 8'h00;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign link.tick = tick_q;
endmodule
`default_nettype wire

// >>> core/fault_tracker.sv
// error counter and fault confinement state for one channel
`timescale 1ns/100ps
`default_nettype none
module fault_tracker
  import can_timing_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic clear,
  input wire logic err_inc,
  input wire logic err_dec,
  output logic [CNT_W-1:0] err_cnt,
  output fault_e state
);
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  fault_e state_q;
  fault_e state_d;

  // ==========================================================
  // counter saturates both ways; frozen once bus off
  always_comb begin
    cnt_d = cnt_q;
    state_d = state_q;
    if (clear) begin
      cnt_d = '0;
      state_d = F_CLEAN;
    end else if (state_q != F_BUS_OFF) begin
      if (err_inc && !err_dec && cnt_q != '1) begin
        cnt_d = cnt_q + 9'h001;
      end else if (err_dec && !err_inc && cnt_q != '0) begin
        cnt_d = cnt_q - 9'h001;
      end
      // the count above 255 sets the top bit
      if (cnt_d[CNT_W-1]) begin
        state_d = F_BUS_OFF;
      end else if (cnt_d > PASSIVE_ABOVE) begin
        state_d = F_ERR_PASSIVE;
      end else if (err_inc || state_q != F_CLEAN) begin
        state_d = F_ERR_ACTIVE;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_q <= '0;
      state_q <= F_CLEAN;
    end else begin
      cnt_q <= cnt_d;
      state_q <= state_d;
    end
  end

  assign err_cnt = cnt_q;
  assign state = state_q;
endmodule
`default_nettype wire

// >>> core/can_bit_timing_fault_state.sv
// bit timing and fault confinement for one can channel, apb registers
//
// Summary of operation
// - the synchronization segment is always exactly one quantum.
// - the quantum is the core clock divided by a 1..256 prescaler.
// - phase segment one spans 1..8 quanta, phase segment two 2..8.
// - the propagation segment spans 1..8 quanta.
// - segment one is propagation plus phase one; below four is rejected.
// - segment two is exactly phase segment two.
// - the bus is sampled where segment one ends and segment two begins.
// - resync moves phase segments by at most the 1..4 jump width.
// - errors seen with count below 128 report error active (light fault).
// - count above 127 reports error passive (heavy fault).
// - count above 255 means bus off, no bus activity, heavy fault.
// - listen-only sends no frames and drives no acknowledge.
// - a deactivated channel reports inactive and stays off the bus.
// - a channel reset request returns it to its initial clean state.
//
// The implementer's own choices: the APB slave port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module can_bit_timing_fault_state
  import can_timing_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic can_rx,
  output logic can_tx,
  input wire logic tx_dominant,
  input wire logic ack_dominant,
  input wire logic err_inc,
  input wire logic err_dec,
  output logic sample_pulse,
  output logic sample_bit,
  output logic bit_start,
  output logic channel_active,
  output logic light_fault_indication,
  output logic heavy_fault_indication,
  output logic bus_off
);
  // ==========================================================
  // declarations
  logic active_q, active_d, listen_q, listen_d, chan_rst_q, chan_rst_d;
  logic cfg_err_q, cfg_err_d;
  logic [7:0] presc_m1_q, presc_m1_d;
  logic [2:0] prop_m1_q, prop_m1_d, ph1_m1_q, ph1_m1_d;
  logic [2:0] ph2_m1_q, ph2_m1_d;
  logic [1:0] sjw_m1_q, sjw_m1_d;
  logic [31:0] prdata_q, prdata_d;
  logic [14:0] bit_div_q, bit_div_d;
  logic addr_hit, wr_en, rd_setup, wr_ok;
  logic [4:0] w_tseg1;
  logic [4:0] tseg1_len, tseg2_len, sjw_len;
  logic [8:0] presc;
  logic [5:0] quanta;
  logic rx_s1_q, rx_s2_q, rx_prev_q, rx_fall;
  seg_e seg_q, seg_d;
  logic [4:0] cnt_q, cnt_d, lim_q, lim_d, lim_eff, cnt_nx, ext, rem;
  logic resync_q, resync_d, edge_q, edge_d, run;
  logic sample_q, sample_d, sbit_q, sbit_d, bstart_q, bstart_d;
  logic can_tx_q, can_tx_d, light_q, light_d, heavy_q, heavy_d;
  logic off_q, off_d, on_bus;
  logic [CNT_W-1:0] err_cnt;
  fault_e fstate;
  tq_link_if tq ();

  // ==========================================================
  // apb decode: zero wait states, unmapped offsets answer with pslverr
  always_comb begin
    unique case (paddr)
      OFS_CTRL, OFS_TIMING, OFS_STATUS, OFS_ERRCNT, OFS_BITDIV:
        addr_hit = 1'b1;
      default: addr_hit = 1'b0;
    endcase
  end
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_hit;
  assign wr_en = psel & penable & pwrite & addr_hit;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign prdata = prdata_q;

  // candidate segment one of a timing write, checked before it lands
  assign w_tseg1 = {2'b00, pwdata[TIM_PROP_LSB +: 3]}
    + {2'b00, pwdata[TIM_PH1_LSB +: 3]} + 5'h02;
  assign wr_ok = (w_tseg1 >= TSEG1_MIN)
    && (pwdata[TIM_PH2_LSB +: 3] >= PH2_M1_MIN);

  // ==========================================================
  // register file next state; read data captured in the setup phase
  always_comb begin
    active_d = active_q;
    listen_d = listen_q;
    chan_rst_d = 1'b0;
    cfg_err_d = cfg_err_q;
    presc_m1_d = presc_m1_q;
    prop_m1_d = prop_m1_q;
    ph1_m1_d = ph1_m1_q;
    ph2_m1_d = ph2_m1_q;
    sjw_m1_d = sjw_m1_q;
    prdata_d = prdata_q;
    if (wr_en && paddr == OFS_CTRL) begin
      active_d = pwdata[CTRL_ACTIVE];
      listen_d = pwdata[CTRL_LISTEN];
      chan_rst_d = pwdata[CTRL_RESET];
    end
    // a rejected setting leaves the running timing untouched
    if (wr_en && paddr == OFS_TIMING) begin
      cfg_err_d = ~wr_ok;
      if (wr_ok) begin
        presc_m1_d = pwdata[TIM_PRESC_LSB +: 8];
        prop_m1_d = pwdata[TIM_PROP_LSB +: 3];
        ph1_m1_d = pwdata[TIM_PH1_LSB +: 3];
        ph2_m1_d = pwdata[TIM_PH2_LSB +: 3];
        sjw_m1_d = pwdata[TIM_SJW_LSB +: 2];
      end
    end
    if (rd_setup) begin
      prdata_d = 32'h0000_0000;
      unique case (paddr)
        OFS_CTRL: begin
          prdata_d[CTRL_ACTIVE] = active_q;
          prdata_d[CTRL_LISTEN] = listen_q;
        end
        OFS_TIMING: begin
          prdata_d[TIM_PRESC_LSB +: 8] = presc_m1_q;
          prdata_d[TIM_PROP_LSB +: 3] = prop_m1_q;
          prdata_d[TIM_PH1_LSB +: 3] = ph1_m1_q;
          prdata_d[TIM_PH2_LSB +: 3] = ph2_m1_q;
          prdata_d[TIM_SJW_LSB +: 2] = sjw_m1_q;
        end
        OFS_STATUS: begin
          prdata_d[ST_ACTIVE] = active_q;
          prdata_d[ST_LISTEN] = listen_q;
          prdata_d[ST_FAULT_LSB +: 2] = fstate;
          prdata_d[ST_LIGHT] = light_q;
          prdata_d[ST_HEAVY] = heavy_q;
          prdata_d[ST_BUS_OFF] = off_q;
          prdata_d[ST_CFG_ERR] = cfg_err_q;
        end
        OFS_ERRCNT: prdata_d[CNT_W-1:0] = err_cnt;
        OFS_BITDIV: prdata_d[14:0] = bit_div_q;
        default: prdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      active_q <= CTRL_ACTIVE_RESET;
      listen_q <= CTRL_LISTEN_RESET;
      chan_rst_q <= 1'b0;
      cfg_err_q <= 1'b0;
      presc_m1_q <= TIMING_RESET[TIM_PRESC_LSB +: 8];
      prop_m1_q <= TIMING_RESET[TIM_PROP_LSB +: 3];
      ph1_m1_q <= TIMING_RESET[TIM_PH1_LSB +: 3];
      ph2_m1_q <= TIMING_RESET[TIM_PH2_LSB +: 3];
      sjw_m1_q <= TIMING_RESET[TIM_SJW_LSB +: 2];
      prdata_q <= 32'h0000_0000;
    end else begin
      active_q <= active_d;
      listen_q <= listen_d;
      chan_rst_q <= chan_rst_d;
      cfg_err_q <= cfg_err_d;
      presc_m1_q <= presc_m1_d;
      prop_m1_q <= prop_m1_d;
      ph1_m1_q <= ph1_m1_d;
      ph2_m1_q <= ph2_m1_d;
      sjw_m1_q <= sjw_m1_d;
      prdata_q <= prdata_d;
    end
  end

  // ==========================================================
  // derived lengths in quanta
  assign tseg1_len = {2'b00, prop_m1_q} + {2'b00, ph1_m1_q} + 5'h02;
  assign tseg2_len = {2'b00, ph2_m1_q} + 5'h01;
  assign sjw_len = {3'b000, sjw_m1_q} + 5'h01;
  assign presc = {1'b0, presc_m1_q} + 9'h001;
  // jump width stays out of the rate
  assign quanta = {1'b0, SYNC_LEN} + {1'b0, tseg1_len} + {1'b0, tseg2_len};
  assign bit_div_d = {6'h00, presc} * {9'h000, quanta};

  // ==========================================================
  // quantum generator, held in restart while the channel is idle
  assign run = active_q & ~chan_rst_q;
  assign tq.div_m1 = presc_m1_q;
  assign tq.restart = ~run;
  tq_prescaler u_tq (
    .clk(clk),
    .reset(reset),
    .link(tq)
  );

  // ==========================================================
  // bus input synchroniser; edge taken past the second stage only
  assign rx_fall = rx_prev_q & ~rx_s2_q;

  // ==========================================================
  // bit segment sequencer with single resync per bit
  assign cnt_nx = cnt_q + 5'h01;
  assign rem = lim_q - cnt_q;
  always_comb begin
    ext = (cnt_nx < sjw_len) ? cnt_nx : sjw_len;
    lim_eff = lim_q;
    if (edge_q && !resync_q) begin
      if (seg_q == SEG_ONE) begin
        lim_eff = lim_q + ext;
      end else if (seg_q == SEG_TWO) begin
        lim_eff = (rem <= sjw_len) ? cnt_nx : lim_q - sjw_len;
      end
    end
  end

  always_comb begin
    seg_d = seg_q;
    cnt_d = cnt_q;
    lim_d = lim_q;
    resync_d = resync_q;
    edge_d = edge_q | rx_fall;
    sample_d = 1'b0;
    sbit_d = sbit_q;
    bstart_d = 1'b0;
    if (!run) begin
      seg_d = SEG_SYNC;
      cnt_d = 5'h00;
      resync_d = 1'b0;
      edge_d = 1'b0;
    end else if (tq.tick) begin
      // a fall in the tick cycle itself is kept for the next quantum
      edge_d = rx_fall;
      if (edge_q && !resync_q && seg_q != SEG_SYNC) begin
        resync_d = 1'b1;
      end
      unique case (seg_q)
        SEG_SYNC: begin
          seg_d = SEG_ONE;
          cnt_d = 5'h00;
          lim_d = tseg1_len;
          resync_d = 1'b0;
          bstart_d = 1'b1;
        end
        SEG_ONE: begin
          cnt_d = cnt_nx;
          lim_d = lim_eff;
          if (cnt_nx >= lim_eff) begin
            seg_d = SEG_TWO;
            cnt_d = 5'h00;
            lim_d = tseg2_len;
            sample_d = 1'b1;
            sbit_d = rx_s2_q;
          end
        end
        SEG_TWO: begin
          cnt_d = cnt_nx;
          lim_d = lim_eff;
          if (cnt_nx >= lim_eff) begin
            seg_d = SEG_SYNC;
            cnt_d = 5'h00;
          end
        end
        default: seg_d = SEG_SYNC;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      seg_q <= SEG_SYNC;
      cnt_q <= 5'h00;
      lim_q <= 5'h00;
      resync_q <= 1'b0;
      edge_q <= 1'b0;
      sample_q <= 1'b0;
      sbit_q <= 1'b1;
      bstart_q <= 1'b0;
      bit_div_q <= 15'h0000;
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
      rx_prev_q <= 1'b1;
    end else begin
      seg_q <= seg_d;
      cnt_q <= cnt_d;
      lim_q <= lim_d;
      resync_q <= resync_d;
      edge_q <= edge_d;
      sample_q <= sample_d;
      sbit_q <= sbit_d;
      bstart_q <= bstart_d;
      bit_div_q <= bit_div_d;
      rx_s1_q <= can_rx;
      rx_s2_q <= rx_s1_q;
      rx_prev_q <= rx_s2_q;
    end
  end

  // ==========================================================
  // fault confinement; events only count while the channel is on
  fault_tracker u_fault (
    .clk(clk),
    .reset(reset),
    .clear(chan_rst_q),
    .err_inc(err_inc & active_q),
    .err_dec(err_dec & active_q),
    .err_cnt(err_cnt),
    .state(fstate)
  );

  // ==========================================================
  // bus drive and fault indications, all registered
  assign on_bus = run & (fstate != F_BUS_OFF);
  always_comb begin
    can_tx_d = 1'b1;
    if (on_bus && !listen_q && (tx_dominant || ack_dominant)) begin
      can_tx_d = 1'b0;
    end
    light_d = active_q && fstate == F_ERR_ACTIVE;
    heavy_d = active_q && (fstate == F_ERR_PASSIVE
      || fstate == F_BUS_OFF);
    off_d = fstate == F_BUS_OFF;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      can_tx_q <= 1'b1;
      light_q <= 1'b0;
      heavy_q <= 1'b0;
      off_q <= 1'b0;
    end else begin
      can_tx_q <= can_tx_d;
      light_q <= light_d;
      heavy_q <= heavy_d;
      off_q <= off_d;
    end
  end

  assign can_tx = can_tx_q;
  assign sample_pulse = sample_q;
  assign sample_bit = sbit_q;
  assign bit_start = bstart_q;
  assign channel_active = active_q;
  assign light_fault_indication = light_q;
  assign heavy_fault_indication = heavy_q;
  assign bus_off = off_q;
endmodule
`default_nettype wire

// >>> test/can_bit_timing_fault_state_props.sv
// port checker for the can bit timing and fault state block
`timescale 1ns/100ps
`default_nettype none
module can_bit_timing_fault_state_props (
  input wire logic clk,
  input wire logic reset,
  input wire logic can_tx,
  input wire logic tx_dominant,
  input wire logic ack_dominant,
  input wire logic sample_pulse,
  input wire logic bit_start,
  input wire logic channel_active,
  input wire logic light_fault_indication,
  input wire logic heavy_fault_indication,
  input wire logic bus_off
);
  // ==========================================================
  // bit timing
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  // segment one is never under four quanta, even at prescaler one
  seg1_min_a: assert property (bit_start |=> !sample_pulse [*3])
    else $error("sample point too soon after bit start");
  // a sync quantum and segment one separate two sample points
  sample_gap_a: assert property (sample_pulse |=> !sample_pulse [*4])
    else $error("sample points too close");
  sample_edge_a: assert property (sample_pulse |-> !bit_start)
    else $error("sample point inside sync segment");
  // ==========================================================
  // fault reporting and bus drive
  faults_excl_a: assert property (!(light_fault_indication &&
    heavy_fault_indication)) else $error("light and heavy both set");
  // one cycle of slack: the indications are registered after control
  idle_quiet_a: assert property (!channel_active &&
    !$past(channel_active) |-> !light_fault_indication &&
    !heavy_fault_indication) else $error("fault shown while inactive");
  idle_recessive_a: assert property (!channel_active &&
    !$past(channel_active) |-> can_tx) else $error("inactive drives bus");
  busoff_heavy_a: assert property (bus_off && channel_active &&
    $past(channel_active) |-> heavy_fault_indication)
    else $error("bus off without heavy fault");
  busoff_silent_a: assert property (bus_off && $past(bus_off)
    |-> can_tx) else $error("bus off channel drives bus");
  drive_cause_a: assert property ($fell(can_tx) |->
    $past(tx_dominant || ack_dominant) && $past(channel_active))
    else $error("dominant without request");
endmodule
`default_nettype wire

// >>> test/can_peer.sv
// far side of the can bus: other nodes wired-and with this channel
`timescale 1ns/100ps
`default_nettype none
module can_peer (
  input wire logic clk,
  input wire logic can_tx,
  input wire logic peer_dom,
  output logic can_rx
);
  logic peer_q;
  // peers switch on a clock edge like any synchronous node
  always_ff @(posedge clk) peer_q <= peer_dom;
  // recessive is the pulled-up idle level, any dominant driver wins
  assign can_rx = can_tx & ~peer_q;
endmodule
`default_nettype wire

// >>> test/can_bit_timing_fault_state_tb_top.sv
// self-checking bench for the can bit timing and fault state block
`timescale 1ns/100ps
`default_nettype none
module can_bit_timing_fault_state_tb_top;
  import can_timing_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, can_rx, can_tx, sample_pulse, sample_bit;
  logic bit_start, channel_active, bus_off;
  logic light_fault_indication, heavy_fault_indication;
  logic tx_dominant = 1'b0, ack_dominant = 1'b0, peer_dom = 1'b0;
  logic err_inc = 1'b0, err_dec = 1'b0;
  int err_total = 0;
  int cmp_count = 0;
  always #2 clk = ~clk;
  can_bit_timing_fault_state can_bit_timing_fault_state_i (.clk, .reset,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .can_rx, .can_tx, .tx_dominant, .ack_dominant, .err_inc, .err_dec,
    .sample_pulse, .sample_bit, .bit_start, .channel_active,
    .light_fault_indication, .heavy_fault_indication, .bus_off);
  can_peer can_peer_i (.clk, .can_tx, .peer_dom, .can_rx);
  // ==========================================================
  // checking and closing
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic timeout();
    err_total++;
    $display("mismatch at %0t: wait ran out", $time);
    summarize();
  endtask
  // ==========================================================
  // apb master, entered just after a rising edge
  task automatic apb(input logic wr, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] r, output logic e);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) timeout();
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // idle cycle so the next setup never lands in the same time step
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    check(r, exp);
  endtask
  // bounded wait for a bit start or a sample point pulse
  task automatic wait_ev(input logic smp, output int n);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while ((smp ? sample_pulse : bit_start) !== 1'b1 && n < 400);
    if (n >= 400) timeout();
  endtask
  // one error event per two cycles, then one cycle to settle
  task automatic errs(input int k, input logic up);
    repeat (k) begin
      err_inc <= up;
      err_dec <= ~up;
      @(posedge clk);
      err_inc <= 1'b0;
      err_dec <= 1'b0;
      @(posedge clk);
    end
    @(posedge clk);
  endtask
  // ==========================================================
  // scenarios
  task automatic s_regs();
    logic [31:0] r;
    logic e;
    rd(OFS_TIMING, TIMING_RESET);
    rd(OFS_CTRL, 32'h0);
    rd(OFS_STATUS, 32'h0);
    rd(OFS_BITDIV, 32'h78);
    apb(1'b0, 8'h14, 32'h0, r, e);
    check({r[30:0], e}, 32'h1);
  endtask
  // upper limits of every field, then a rejected segment one sum and a rejected phase two, then the fast setting
  task automatic s_timing();
    logic [31:0] tim [4] = '{32'h0037_77FF, 32'h0001_1000, 32'h0000_2000,
      32'h0001_2000};
    logic [31:0] div [4] = '{32'h1900, 32'h1900, 32'h1900, 32'h7};
    logic bad [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
    logic [31:0] cur;
    logic [31:0] r;
    logic e;
    cur = TIMING_RESET;
    for (int i = 0; i < 4; i++) begin
      wr(OFS_TIMING, tim[i]);
      if (!bad[i]) cur = tim[i];
      rd(OFS_TIMING, cur);
      rd(OFS_BITDIV, div[i]);
      apb(1'b0, OFS_STATUS, 32'h0, r, e);
      check({31'h0, r[ST_CFG_ERR]}, {31'h0, bad[i]});
    end
  endtask
  // prescaler one, segment one four, segment two two quanta
  task automatic s_bit();
    int n;
    wr(OFS_CTRL, 32'h1);
    wait_ev(1'b0, n);
    wait_ev(1'b1, n);
    check(n, 32'h4);
    wait_ev(1'b0, n);
    check(n, 32'h3);
    // a fall early in segment one stretches it by the jump width
    wait_ev(1'b1, n);
    peer_dom <= 1'b1;
    wait_ev(1'b0, n);
    wait_ev(1'b1, n);
    check(n, 32'h5);
    @(posedge clk);
    check(sample_bit, 32'h0);
    peer_dom <= 1'b0;
    repeat (2) wait_ev(1'b1, n);
    @(posedge clk);
    check(sample_bit, 32'h1);
  endtask
  task automatic s_drive();
    logic [31:0] r;
    logic e;
    tx_dominant <= 1'b1;
    repeat (3) @(posedge clk);
    check(can_tx, 32'h0);
    tx_dominant <= 1'b0;
    ack_dominant <= 1'b1;
    wr(OFS_CTRL, 32'h3);
    repeat (2) @(posedge clk);
    check(can_tx, 32'h1);
    apb(1'b0, OFS_STATUS, 32'h0, r, e);
    check(r[ST_LISTEN], 32'h1);
    ack_dominant <= 1'b0;
    wr(OFS_CTRL, 32'h1);
  endtask
  task automatic s_fault();
    errs(1, 1'b1);
    check({light_fault_indication, heavy_fault_indication}, 32'h2);
    errs(127, 1'b1);
    check({light_fault_indication, heavy_fault_indication}, 32'h1);
    errs(1, 1'b0);
    check({light_fault_indication, heavy_fault_indication}, 32'h2);
    errs(129, 1'b1);
    check({bus_off, heavy_fault_indication}, 32'h3);
    rd(OFS_ERRCNT, 32'h100);
    tx_dominant <= 1'b1;
    repeat (3) @(posedge clk);
    check(can_tx, 32'h1);
    tx_dominant <= 1'b0;
    wr(OFS_CTRL, 32'h5);
    repeat (2) @(posedge clk);
    check({bus_off, heavy_fault_indication}, 32'h0);
    rd(OFS_ERRCNT, 32'h0);
    rd(OFS_STATUS, 32'h1);
    wr(OFS_CTRL, 32'h0);
    errs(1, 1'b1);
    rd(OFS_ERRCNT, 32'h0);
    check(channel_active, 32'h0);
    rd(OFS_STATUS, 32'h0);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    s_regs();
    s_timing();
    s_bit();
    s_drive();
    s_fault();
    summarize();
  end
endmodule
bind can_bit_timing_fault_state can_bit_timing_fault_state_props
  can_bit_timing_fault_state_props_i (.clk, .reset, .can_tx, .tx_dominant,
  .ack_dominant, .sample_pulse, .bit_start, .channel_active,
  .light_fault_indication, .heavy_fault_indication, .bus_off);
`default_nettype wire
